//--- rtl/acl_consts.vh
// constants for the filter rule indirect access path
// assumes byte-wide host register accesses on the system clock
`ifndef ACL_CONSTS_VH
`define ACL_CONSTS_VH

// direct host register addresses
`define ADDR_INDIRECT_SELECT  8'h6E
`define ADDR_INDIRECT_OFFSET  8'h6F
`define ADDR_INDIRECT_DATA    8'hA0

// select register fields
`define SEL_SPACE_MSB         7
`define SEL_SPACE_LSB         5
`define SEL_READ_BIT          4
`define SPACE_RULE            3'h2
`define SPACE_POWER           3'h1
`define SEL_GLOBAL_PORT       4'h0
`define NUM_PORTS             5

// rule space offsets
`define RULE_ENTRY_BYTES      8'h0E
`define OFS_BE_UPPER          8'h10
`define OFS_BE_LOWER          8'h11
`define OFS_ACCESS_CTRL       8'h12
`define CTRL_DIR_BIT          4
`define CTRL_WR_DONE_BIT      6
`define CTRL_RD_DONE_BIT      5

// global power-saving space
`define OFS_QB_CTRL_HIGH      8'h30
`define OFS_QB_CTRL_LOW       8'h31
`define QB_CTRL_HIGH_VALUE    8'h40
`define QB_CTRL_LOW_RESERVED  7'h10
`define QB_LPI_EN_RESET       1'b0

// entry layout: mode field sits in entry byte 1
`define MODE_BYTE             1
`define MODE_LSB              4
`define MODE_LAYER2           2'h1

// reset values
`define SELECT_RESET          8'h00
`define OFFSET_RESET          8'h00
`define BE_RESET              8'h00
`define CTRL_RESET            5'h00

// transfer timing: 400 ns at 100 ns per cycle
`define XFER_TIME_NS          400
`define CLK_PERIOD_NS         100
`define XFER_CYCLES           (`XFER_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- rtl/rule_table_mem.v
// rule table storage: 5 ports x 16 entries of 14 bytes
// assumes a single writer/reader, the transfer engine
`timescale 1ns/100ps
module rule_table_mem (
  // clock
  input  wire         clk_sys,
  // access
  input  wire         en,
  input  wire         we,
  input  wire [6:0]   addr,
  input  wire [111:0] wdata,
  input  wire [13:0]  be,
  output reg  [111:0] rdata
);
  reg [111:0] mem [0:79];
  integer k;

  // byte-masked write keeps disabled bytes untouched; registered read
  always @(posedge clk_sys) begin
    if (en) begin
      if (we) begin
        for (k = 0; k < 14; k = k + 1) begin
          if (be[k])
            mem[addr][k*8 +: 8] <= wdata[k*8 +: 8];
        end
      end else begin
        rdata <= mem[addr];
      end
    end
  end
endmodule // rule_table_mem

//--- rtl/rule_xfer_engine.v
// sequencer for one table transfer between holding buffer and table
// assumes start is a one-cycle pulse only given while busy is low
`timescale 1ns/100ps
`include "acl_consts.vh"
module rule_xfer_engine (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // request
  input  wire       start,
  input  wire       start_write,
  input  wire [2:0] start_port,
  input  wire [3:0] start_index,
  // status
  output wire       busy,
  output reg        done,
  output reg        xfer_write,
  output reg  [2:0] xfer_port,
  // table access
  output wire       mem_en,
  output wire       mem_we,
  output wire [6:0] mem_addr
);
  localparam IDLE   = 2'h0;
  localparam ACCESS = 2'h1;
  localparam HOLD   = 2'h2;

  reg [1:0] state;
  reg [3:0] index;
  reg [7:0] count;

  assign busy     = (state != IDLE);
  assign mem_en   = (state == ACCESS);
  assign mem_we   = (state == ACCESS) && xfer_write;
  assign mem_addr = {xfer_port, index};

  // hold busy for the full transfer time so flags stay low long enough to see
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= IDLE;
      index      <= 4'h0;
      count      <= 8'h00;
      done       <= 1'b0;
      xfer_write <= 1'b0;
      xfer_port  <= 3'h0;
    end else begin
      done <= 1'b0;
      case (state)
        IDLE: begin
          if (start) begin
            xfer_write <= start_write;
            xfer_port  <= start_port;
            index      <= start_index;
            count      <= 8'h00;
            state      <= ACCESS;
          end
        end
        ACCESS: begin
          count <= 8'h01;
          state <= HOLD;
        end
        HOLD: begin
          if (count >= `XFER_CYCLES - 1) begin
            done  <= 1'b1;
            state <= IDLE;
          end else begin
            count <= count + 8'h01;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
endmodule // rule_xfer_engine

//--- rtl/acl_indirect_access.v
// indirect access path to per-port filter rule tables and power-saving space
// assumes byte host register strobes from the serial port decoder on clk_sys
//
// How it works
// - select 0x41..0x45 picks port 1..5 rule space, write direction
// - select 0x51..0x55 picks the same, read direction; bit 4 is direction
// - select bits 7:5 = 010 means rule space, bits 3:0 the port
// - writing the offset register latches offset and fetches or arms access
// - data register 0xA0 carries the byte to or from the addressed location
// - 14-bit byte enable at 0x10/0x11 picks entry bytes taking part
// - upper bits 5:0 map bytes 0..5, lower bits 7:0 map bytes 6..13
// - writing control 0x12 starts transfer of entry bits 3:0, bit 4 writes
// - control bit 5 shows read completion; host polls it before fetching
// - control bit 6 shows write completion; host polls before loading
// - completed read leaves enabled entry bytes in holding buffer 0x00..0x0D
// - table write copies only enabled bytes, others stay unchanged
// - entry byte 1 mode field picks the entry format; 01 is layer 2
// - power-saving logic acts on copper ports only, via indirect path
// - select 001 with port 0 reaches global space; buffer control at 0x30
// - buffer control bit 7 lets input traffic cancel pending idle request
// - completion flags read 1 after reset, 0 while operation in progress
`timescale 1ns/100ps
`include "acl_consts.vh"
module acl_indirect_access #(
  parameter [4:0] COPPER_PORTS = 5'h1F
) (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst,
  // host register access
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // power saving, per port
  input  wire [4:0] traffic_in,
  input  wire [4:0] lpi_request,
  output reg  [4:0] lpi_cancel,
  // format of the last transferred entry
  output reg  [1:0] entry_format
);
  reg [7:0] sel;
  reg [7:0] offset;
  reg [7:0] data_byte;
  reg [7:0] hold [0:69];
  reg [7:0] be_upper [0:4];
  reg [7:0] be_lower [0:4];
  reg [4:0] ctrl [0:4];
  reg [4:0] rd_done;
  reg [4:0] wr_done;
  reg       qb_lpi_en;
  reg [4:0] traffic_meta;
  reg [4:0] traffic_sync;
  reg       start;
  reg       start_write;
  reg [2:0] start_port;
  reg [3:0] start_index;

  wire         eng_busy;
  wire         eng_done;
  wire         eng_write;
  wire [2:0]   eng_port;
  wire         mem_en;
  wire         mem_we;
  wire [6:0]   mem_addr;
  wire [111:0] row_wdata;
  wire [111:0] row_rdata;
  wire [13:0]  row_be;
  wire [13:0]  be_word;

  integer i;

  // select decode used by reads, writes and triggers
  function port_ok;
    input [7:0] s;
    begin
      port_ok = (s[3:0] >= 4'h1) && (s[3:0] <= 4'h5);
    end
  endfunction

  function is_rule;
    input [7:0] s;
    begin
      is_rule = (s[`SEL_SPACE_MSB:`SEL_SPACE_LSB] == `SPACE_RULE) && port_ok(s);
    end
  endfunction

  function is_power_global;
    input [7:0] s;
    begin
      is_power_global = (s[`SEL_SPACE_MSB:`SEL_SPACE_LSB] == `SPACE_POWER) &&
                        (s[3:0] == `SEL_GLOBAL_PORT);
    end
  endfunction

  function [2:0] port_idx;
    input [7:0] s;
    begin
      port_idx = s[2:0] - 3'h1;
    end
  endfunction

  function [6:0] hold_idx;
    input [2:0] p;
    input [7:0] o;
    begin
      hold_idx = (p * 7'h0E) + o[6:0];
    end
  endfunction

  // value seen at an indirect location; unmapped locations read zero
  function [7:0] read_loc;
    input [7:0] s;
    input [7:0] o;
    reg   [2:0] p;
    begin
      read_loc = 8'h00;
      p = port_idx(s);
      if (is_rule(s)) begin
        if (o < `RULE_ENTRY_BYTES)
          read_loc = hold[hold_idx(p, o)];
        else if (o == `OFS_BE_UPPER)
          read_loc = be_upper[p];
        else if (o == `OFS_BE_LOWER)
          read_loc = be_lower[p];
        else if (o == `OFS_ACCESS_CTRL)
          read_loc = {1'b0, wr_done[p], rd_done[p], ctrl[p]};
      end else if (is_power_global(s)) begin
        if (o == `OFS_QB_CTRL_HIGH)
          read_loc = `QB_CTRL_HIGH_VALUE;
        else if (o == `OFS_QB_CTRL_LOW)
          read_loc = {qb_lpi_en, `QB_CTRL_LOW_RESERVED};
      end
    end
  endfunction

  // byte k of an entry is enabled by bit 13-k of the joined word
  assign be_word = {be_upper[eng_port][5:0], be_lower[eng_port]};

  genvar k;
  generate
    for (k = 0; k < 14; k = k + 1) begin : g_row
      // byte number at the width the buffer index function takes
      localparam [7:0] BYTE_OFS    = k;
      assign row_be[k]             = be_word[13 - k];
      assign row_wdata[k*8 +: 8]   = hold[hold_idx(eng_port, BYTE_OFS)];
    end
  endgenerate

  // direct registers, data byte and start requests
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sel         <= `SELECT_RESET;
      offset      <= `OFFSET_RESET;
      data_byte   <= 8'h00;
      reg_rdata   <= 8'h00;
      qb_lpi_en   <= `QB_LPI_EN_RESET;
      rd_done     <= 5'h1F;
      wr_done     <= 5'h1F;
      start       <= 1'b0;
      start_write <= 1'b0;
      start_port  <= 3'h0;
      start_index <= 4'h0;
      for (i = 0; i < 70; i = i + 1)
        hold[i] <= 8'h00;
      for (i = 0; i < `NUM_PORTS; i = i + 1) begin
        be_upper[i] <= `BE_RESET;
        be_lower[i] <= `BE_RESET;
        ctrl[i]     <= `CTRL_RESET;
      end
    end else begin
      start <= 1'b0;
      // register reads: data byte is returned, then in read direction the next byte is prefetched
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_INDIRECT_SELECT: reg_rdata <= sel;
          `ADDR_INDIRECT_OFFSET: reg_rdata <= offset;
          `ADDR_INDIRECT_DATA: begin
            reg_rdata <= data_byte;
            if (sel[`SEL_READ_BIT]) begin
              offset    <= offset + 8'h01;
              data_byte <= read_loc(sel, offset + 8'h01);
            end
          end
          default: reg_rdata <= 8'h00;
        endcase
      end
      if (reg_wr) begin
        case (reg_addr)
          `ADDR_INDIRECT_SELECT: sel <= reg_wdata;
          `ADDR_INDIRECT_OFFSET: begin
            offset <= reg_wdata;
            if (sel[`SEL_READ_BIT])
              data_byte <= read_loc(sel, reg_wdata);
          end
          `ADDR_INDIRECT_DATA: begin
            data_byte <= reg_wdata;
            if (!sel[`SEL_READ_BIT]) begin
              offset <= offset + 8'h01; // burst write steps the offset
              if (is_rule(sel)) begin
                if (offset < `RULE_ENTRY_BYTES)
                  hold[hold_idx(port_idx(sel), offset)] <= reg_wdata;
                else if (offset == `OFS_BE_UPPER)
                  be_upper[port_idx(sel)] <= reg_wdata;
                else if (offset == `OFS_BE_LOWER)
                  be_lower[port_idx(sel)] <= reg_wdata;
                else if (offset == `OFS_ACCESS_CTRL) begin
                  ctrl[port_idx(sel)] <= reg_wdata[4:0];
                  // a start while a transfer runs is dropped; host must poll
                  if (!eng_busy && !start) begin
                    start       <= 1'b1;
                    start_write <= reg_wdata[`CTRL_DIR_BIT];
                    start_port  <= port_idx(sel);
                    start_index <= reg_wdata[3:0];
                    if (reg_wdata[`CTRL_DIR_BIT])
                      wr_done[port_idx(sel)] <= 1'b0;
                    else
                      rd_done[port_idx(sel)] <= 1'b0;
                  end
                end
              end else if (is_power_global(sel) && offset == `OFS_QB_CTRL_LOW) begin
                qb_lpi_en <= reg_wdata[7];
              end
            end
          end
          default: ;
        endcase
      end
      // completion: read result lands in holding buffer, flag set wins
      if (eng_done) begin
        if (eng_write) begin
          wr_done[eng_port] <= 1'b1;
        end else begin
          rd_done[eng_port] <= 1'b1;
          for (i = 0; i < 14; i = i + 1) begin
            if (row_be[i])
              hold[hold_idx(eng_port, i[7:0])] <= row_rdata[i*8 +: 8];
          end
        end
      end
    end
  end

  // entry format follows the mode field of the transferred row
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      entry_format <= `MODE_LAYER2;
    end else if (eng_done) begin
      if (eng_write)
        entry_format <= row_wdata[`MODE_BYTE*8 + `MODE_LSB +: 2];
      else
        entry_format <= row_rdata[`MODE_BYTE*8 + `MODE_LSB +: 2];
    end
  end

  // traffic pins are asynchronous, so two flops before any use
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      traffic_meta <= 5'h00;
      traffic_sync <= 5'h00;
      lpi_cancel   <= 5'h00;
    end else begin
      traffic_meta <= traffic_in;
      traffic_sync <= traffic_meta;
      // only copper ports carry idle requests that traffic may cancel
      lpi_cancel <= {5{qb_lpi_en}} & traffic_sync & lpi_request & COPPER_PORTS;
    end
  end

  rule_xfer_engine u_engine (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .start       (start),
    .start_write (start_write),
    .start_port  (start_port),
    .start_index (start_index),
    .busy        (eng_busy),
    .done        (eng_done),
    .xfer_write  (eng_write),
    .xfer_port   (eng_port),
    .mem_en      (mem_en),
    .mem_we      (mem_we),
    .mem_addr    (mem_addr)
  );

  // the mask keeps bytes outside the enable word unchanged in the table
  rule_table_mem u_table (
    .clk_sys (clk_sys),
    .en      (mem_en),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (row_wdata),
    .be      (row_be),
    .rdata   (row_rdata)
  );
endmodule // acl_indirect_access

//--- test/host_model.sv
// host model: drives byte register strobes into the indirect access path
// assumes the device answers a read one cycle after the strobe edge
`timescale 1ns/100ps
module host_model (
  // clock
  input  wire       clk_sys,
  // register bus
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // one strobe cycle, then an idle cycle so two strobes never merge
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr    = 1'b0;
      reg_wdata = ~d; // released data must not look valid
    end
  endtask

  // answer is registered, so it is taken one cycle after the strobe
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk_sys);
      reg_rd   = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd   = 1'b0;
      d        = reg_rdata;
    end
  endtask

  // bounded status poll: rewrite the control offset, then fetch it
  task poll(input [7:0] sel, input integer b, output reg ok);
    reg [7:0] v;
    integer   n;
    begin
      ok = 1'b0;
      wr(8'h6E, sel);
      for (n = 0; n < 20 && !ok; n = n + 1) begin
        wr(8'h6F, 8'h12);
        rd(8'hA0, v);
        ok = (v[b] === 1'b1);
      end
    end
  endtask
endmodule // host_model

//--- test/acl_indirect_access_chk.sv
// checker for the indirect access path, sees only the top module's ports
// assumes one clock domain and the register strobes of the host model
`timescale 1ns/100ps
module acl_indirect_access_chk (
  // clock and reset
  input wire       clk_sys,
  input wire       rst,
  // register bus
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // power saving
  input wire [4:0] traffic_in,
  input wire [4:0] lpi_request,
  input wire [4:0] lpi_cancel,
  input wire [1:0] entry_format
);
  reg [7:0] since_go;

  // cycles since the last data byte write, saturating so it never wraps
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      since_go <= 8'hFF;
    else if (reg_wr && reg_addr == 8'hA0)
      since_go <= 8'h00;
    else if (since_go != 8'hFF)
      since_go <= since_go + 8'h01;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_RDATA_HOLDS: assert property ($changed(reg_rdata) |-> $past(reg_rd))
    else $error("read data changed without a read");
  AST_UNMAPPED_ZERO: assert property (reg_rd && !(reg_addr inside {8'h6E, 8'h6F, 8'hA0})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_SEL_READBACK: assert property (reg_wr && reg_addr == 8'h6E ##2 reg_rd && reg_addr == 8'h6E
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("select readback wrong");
  AST_OFS_READBACK: assert property (reg_wr && reg_addr == 8'h6F ##1 !reg_wr ##1
    reg_rd && reg_addr == 8'h6F |=> reg_rdata == $past(reg_wdata, 3))
    else $error("offset readback wrong");
  AST_CANCEL_REQ: assert property ((lpi_cancel & ~$past(lpi_request)) == 5'h00)
    else $error("cancel without idle request");
  AST_CANCEL_TRAFFIC: assert property ((lpi_cancel & ~$past(traffic_in, 3)) == 5'h00)
    else $error("cancel without traffic");
  AST_RESET_VALUES: assert property ($fell(rst) |-> reg_rdata == 8'h00
    && lpi_cancel == 5'h00 && entry_format == 2'h1) else $error("reset values wrong");
  AST_FORMAT_CAUSE: assert property (!$stable(entry_format) |-> since_go < 8'h0A)
    else $error("format changed without a transfer");

  // main scenarios
  cover property (reg_wr && reg_addr == 8'hA0 && reg_wdata == 8'h1F);
  cover property (lpi_cancel != 5'h00);
  cover property (!$stable(entry_format));
endmodule // acl_indirect_access_chk

bind acl_indirect_access acl_indirect_access_chk acl_indirect_access_chk_inst (
  .clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .traffic_in, .lpi_request, .lpi_cancel, .entry_format);

//--- test/testbench.sv
// self-checking bench for the indirect access path
// assumes host_model speaks the byte strobe protocol of the design
`timescale 1ns/100ps
module testbench;
  reg        clk_sys;
  reg        rst;
  reg  [4:0] traffic_in;
  reg  [4:0] lpi_request;
  wire       reg_wr;
  wire       reg_rd;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire [4:0] lpi_cancel;
  wire [1:0] entry_format;
  integer    fails;
  integer    comparisons;
  integer    k;
  reg        ok;

  // clock, 100 ns period
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  acl_indirect_access acl_indirect_access_inst (.clk_sys, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .traffic_in, .lpi_request, .lpi_cancel,
    .entry_format);
  host_model host_model_inst (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata);

  // compare and count
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task w(input [7:0] a, input [7:0] d);
    host_model_inst.wr(a, d);
  endtask

  task r(input [7:0] a, input [7:0] exp);
    reg [7:0] v;
    begin
      host_model_inst.rd(a, v);
      chk(v, exp);
    end
  endtask

  // fill the holding buffer with base|k, bytes 0..13 as one burst
  task load(input [7:0] sel, input [7:0] base);
    begin
      w(8'h6E, sel);
      w(8'h6F, 8'h00);
      for (k = 0; k < 14; k = k + 1)
        w(8'hA0, base | k[7:0]);
    end
  endtask

  // enables as a burst, then the control byte starts the transfer
  task xfer(input [7:0] sel, input [7:0] hi, input [7:0] lo, input [7:0] ctl);
    begin
      w(8'h6E, sel);
      w(8'h6F, 8'h10);
      w(8'hA0, hi);
      w(8'hA0, lo);
      w(8'h6F, 8'h12);
      w(8'hA0, ctl);
    end
  endtask

  task conclude;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    fails = fails + 1;
    conclude;
  end

  initial begin
    fails       = 0;
    comparisons = 0;
    rst         = 1'b1;
    traffic_in  = 5'h1F;
    lpi_request = 5'h05;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    // traffic is ignored while cancelling is disabled by default
    repeat (4) @(negedge clk_sys);
    chk({3'h0, lpi_cancel}, 8'h00); // default off
    // select and offset read back, flags idle after reset
    w(8'h6E, 8'h51);
    r(8'h6E, 8'h51); // read direction select
    w(8'h6F, 8'h12);
    r(8'h6F, 8'h12); // offset latched
    r(8'hA0, 8'h60); // both flags set
    r(8'h33, 8'h00); // unmapped direct address
    // full write of port 5 entry 15, mode field 10
    load(8'h45, 8'hA0);
    xfer(8'h45, 8'h3F, 8'hFF, 8'h1F);
    w(8'h6E, 8'h55);
    w(8'h6F, 8'h12);
    r(8'hA0, 8'h3F); // write flag low while running
    host_model_inst.poll(8'h55, 6, ok);
    chk({7'h00, ok}, 8'h01); // write completes
    w(8'h6F, 8'h12);
    r(8'hA0, 8'h7F); // flags back with control bits
    chk({6'h00, entry_format}, 8'h02); // mode field 10
    // odd bytes only, then read the whole entry back
    load(8'h45, 8'h50);
    xfer(8'h45, 8'h15, 8'h55, 8'h1F);
    host_model_inst.poll(8'h55, 6, ok);
    chk({7'h00, ok}, 8'h01); // masked write completes
    xfer(8'h45, 8'h3F, 8'hFF, 8'h0F); // read entry 15
    w(8'h6E, 8'h55);
    w(8'h6F, 8'h12);
    r(8'hA0, 8'h4F); // read flag low while running
    host_model_inst.poll(8'h55, 5, ok);
    chk({7'h00, ok}, 8'h01); // read completes
    w(8'h6F, 8'h00);
    for (k = 0; k < 14; k = k + 1)
      r(8'hA0, (k % 2) ? (8'h50 | k[7:0]) : (8'hA0 | k[7:0]));
    chk({6'h00, entry_format}, 8'h01); // layer 2 mode
    // global power space: enable cancel, try the read-only byte
    w(8'h6E, 8'h20);
    w(8'h6F, 8'h31);
    w(8'hA0, 8'h80);
    w(8'h6F, 8'h30);
    w(8'hA0, 8'hFF); // ignored
    w(8'h6E, 8'h30);
    w(8'h6F, 8'h30);
    r(8'hA0, 8'h40); // fixed upper byte
    r(8'hA0, 8'h90); // burst to low byte
    repeat (4) @(negedge clk_sys);
    chk({3'h0, lpi_cancel}, 8'h05); // only requesting ports cancel
    // disable again: traffic must no longer cancel
    w(8'h6E, 8'h20);
    w(8'h6F, 8'h31);
    w(8'hA0, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk({3'h0, lpi_cancel}, 8'h00); // disabled
    conclude;
  end
endmodule // testbench
